/* shared/strap_pkg.sv */
// package: constants and carrier types for the strap latch and mii pin sharing block
package strap_pkg;

  // apb register map (byte addresses)
  localparam logic [11:0] reg_strap_ofs = 12'h000;  // captured straps, read only
  localparam logic [11:0] reg_ctrl_ofs = 12'h004;   // control bits
  localparam logic [11:0] reg_irq_ofs = 12'h008;    // interrupt enable / status
  localparam logic [11:0] reg_wake_ofs = 12'h00c;   // wake event status

  // strap register field positions
  localparam int addr_lsb = 0;      // mgmt_address[2:0]
  localparam int duplex_bit = 3;
  localparam int cfg2_bit = 4;
  localparam int bcast_bit = 5;
  localparam int iso_bit = 6;
  localparam int nand_bit = 7;
  localparam int wake_en_bit = 8;

  // control register field positions
  localparam int pol_bit = 9;        // interrupt polarity, 1 = active high
  localparam int pin_opt2_bit = 0;   // pin used as wake_event_out_opt2
  localparam int b2b_bit = 1;        // back-to-back repeater mode

  localparam int irq_w = 8;          // interrupt condition count
  localparam int irq_en_lsb = 16;    // interrupt enable field, upper half of the irq register
  localparam logic [31:0] ctrl_rst = 32'h0000_0000;
  localparam logic [irq_w-1:0] irq_zero = 8'h00;

  // latched straps
  typedef struct packed {
    logic [2:0] mgmt_address;
    logic duplex;
    logic mode_cfg_strap_bit2;
    logic broadcast_disable_strap;
    logic isolate;
    logic nand_tree;
    logic wake_out_enable_strap;
  } straps_t;

  localparam straps_t straps_rst = '0;

  // shared pin group: one entry per two-way pin
  typedef struct packed {
    logic [3:0] rxd;
    logic rxdv;
    logic rxc;
    logic rxer;
    logic irq;
    logic txc;
  } pins_t;

  // receive side data from the phy core
  typedef struct packed {
    logic [3:0] rxd;
    logic rxdv;
    logic rxer;
  } rx_word_t;

endpackage : strap_pkg

/* core/strap_capture.sv */
// strap capture: synchronise shared pins and latch them once on reset release
`timescale 1ns/10ps
`default_nettype none
module strap_capture
  import strap_pkg::*;
(
  input wire logic clk_sys,        // system clock
  input wire logic nrst,           // async reset, active low
  input wire logic ce,             // clock enable
  input wire pins_t pin_i,         // pin levels
  output straps_t straps,          // latched strap values
  output logic done                // straps have been taken
);

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic v1;
    logic v2;
    logic taken;
    straps_t st;
  } cap_state_t;

  cap_state_t cur_q;
  cap_state_t cur_d;

  // capture on the third enabled cycle after release, never again
  always_comb begin
    cur_d = cur_q;
    if (ce) begin
      cur_d.s1 = pin_i;
      cur_d.s2 = cur_q.s1;
      cur_d.v1 = 1'b1;
      cur_d.v2 = cur_q.v1;
      // s2 still holds its reset value until v2 is set, so wait for it
      if (cur_q.v2 && !cur_q.taken) begin
        cur_d.taken = 1'b1;
        cur_d.st.mgmt_address = {cur_q.s2.rxd[1], cur_q.s2.rxd[2], cur_q.s2.rxd[3]};
        cur_d.st.duplex = cur_q.s2.rxd[0];
        cur_d.st.mode_cfg_strap_bit2 = cur_q.s2.rxdv;
        cur_d.st.broadcast_disable_strap = cur_q.s2.rxc;
        cur_d.st.isolate = cur_q.s2.rxer;
        cur_d.st.nand_tree = cur_q.s2.irq;
        cur_d.st.wake_out_enable_strap = cur_q.s2.txc;
      end
    end
  end

  // sampling waits two cycles so the synchroniser holds real pin levels
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur_q <= '0;
    end else begin
      cur_q <= cur_d;
    end
  end

  assign straps = cur_q.st;
  assign done = cur_q.taken;

  a_straps_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(cur_q.taken) |-> $stable(cur_q.st)) else $error("strap changed after capture");

endmodule : strap_capture
`default_nettype wire

/* core/mii_pin_share.sv */
// mii pin sharing: strap capture, pin drive control, interrupt pin and apb registers
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module mii_pin_share
  import strap_pkg::*;
(
  input wire logic clk_sys,          // system clock, 250 mhz
  input wire logic nrst,             // async reset, active low
  input wire logic ce,               // clock enable
  input wire logic clk_mii,          // mii link clock
  input wire logic psel,             // apb select
  input wire logic penable,          // apb enable
  input wire logic pwrite,           // apb direction
  input wire logic [11:0] paddr,     // apb address
  input wire logic [31:0] pwdata,    // apb write data
  output logic [31:0] prdata,        // apb read data
  output logic pready,               // apb ready
  output logic pslverr,              // apb error
  input wire logic [irq_w-1:0] irq_event, // interrupt condition pulses
  input wire logic lan_wakeup,       // wake event pulse
  input wire rx_word_t rx_in,        // receive word from phy core
  input wire logic tx_clk_gen,       // generated transmit clock level
  input wire pins_t pin_i,           // shared pin input levels
  output pins_t pin_o,               // shared pin output levels
  output pins_t pin_oe,              // shared pin output enables
  input wire logic txen_pin,         // mac transmit enable pin
  input wire logic [3:0] txd_pin,    // mac transmit data pins
  output logic [3:0] tx_nibble,      // transmit nibble, link clock
  output logic tx_valid,             // transmit nibble valid
  output straps_t straps             // latched straps
);

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture

  logic strap_done;

  strap_capture u_cap (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .pin_i(pin_i),
    .straps(straps),
    .done(strap_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // system domain state

  typedef struct packed {
    logic [31:0] ctrl;
    logic [irq_w-1:0] irq_en;
    logic [irq_w-1:0] irq_stat;
    logic wake_stat;
    logic [31:0] rdata;
    logic irq_act;
    logic wake_act;
    logic drive_en;
  } sys_state_t;

  sys_state_t cur_q;
  sys_state_t cur_d;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic acc;
  logic wr;
  logic rd;

  // zero wait state slave
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;
  assign pslverr = acc && !(hit(paddr, reg_strap_ofs) || hit(paddr, reg_ctrl_ofs) ||
                            hit(paddr, reg_irq_ofs) || hit(paddr, reg_wake_ofs));

  logic [31:0] strap_rd;

  // strap word laid out by field positions, not by the struct packing order
  always_comb begin
    strap_rd = 32'h0000_0000;
    strap_rd[addr_lsb +: 3] = straps.mgmt_address;
    strap_rd[duplex_bit] = straps.duplex;
    strap_rd[cfg2_bit] = straps.mode_cfg_strap_bit2;
    strap_rd[bcast_bit] = straps.broadcast_disable_strap;
    strap_rd[iso_bit] = straps.isolate;
    strap_rd[nand_bit] = straps.nand_tree;
    strap_rd[wake_en_bit] = straps.wake_out_enable_strap;
  end

  // register file, status set wins over write-one-to-clear
  always_comb begin
    cur_d = cur_q;
    if (ce) begin
      if (wr && hit(paddr, reg_ctrl_ofs)) begin
        cur_d.ctrl = pwdata;
      end
      if (wr && hit(paddr, reg_irq_ofs)) begin
        cur_d.irq_en = pwdata[irq_en_lsb +: irq_w];
        cur_d.irq_stat = cur_q.irq_stat & ~pwdata[irq_w-1:0];
      end
      cur_d.irq_stat = cur_d.irq_stat | irq_event;
      if (wr && hit(paddr, reg_wake_ofs)) begin
        cur_d.wake_stat = cur_q.wake_stat & ~pwdata[0];
      end
      cur_d.wake_stat = cur_d.wake_stat | lan_wakeup;
      cur_d.rdata = 32'h0000_0000;
      if (rd || (psel && !penable)) begin
        unique case (1'b1)
          hit(paddr, reg_strap_ofs): cur_d.rdata = strap_rd;
          hit(paddr, reg_ctrl_ofs): cur_d.rdata = cur_q.ctrl;
          hit(paddr, reg_irq_ofs): cur_d.rdata = {8'h00, cur_q.irq_en, 8'h00, cur_q.irq_stat};
          hit(paddr, reg_wake_ofs): cur_d.rdata = {31'h00000000, cur_q.wake_stat};
          default: cur_d.rdata = 32'h0000_0000;
        endcase
      end
      cur_d.irq_act = |(cur_d.irq_stat & cur_d.irq_en);
      cur_d.wake_act = cur_d.wake_stat && straps.wake_out_enable_strap;
      cur_d.drive_en = strap_done;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur_q <= '0;
    end else begin
      cur_q <= cur_d;
    end
  end

  // read data is registered during setup, so it is ready at the access cycle
  assign prdata = cur_q.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // pin drive

  logic opt2;
  logic pol_high;
  assign opt2 = cur_q.ctrl[pin_opt2_bit];
  assign pol_high = cur_q.ctrl[pol_bit];

  // pins stay inputs until the straps are taken so board pulls are read
  always_comb begin
    pin_o = '0;
    pin_oe = '0;
    if (cur_q.drive_en) begin
      pin_o.rxd = rx_in.rxd;
      pin_o.rxdv = rx_in.rxdv;
      pin_o.rxer = rx_in.rxer;
      pin_o.rxc = clk_mii;
      pin_oe.rxd = 4'hf;
      pin_oe.rxdv = 1'b1;
      pin_oe.rxer = 1'b1;
      pin_oe.rxc = 1'b1;
      pin_o.txc = tx_clk_gen;
      pin_oe.txc = !cur_q.ctrl[b2b_bit];
      if (opt2) begin
        pin_oe.irq = cur_q.wake_act;
      end else if (pol_high) begin
        pin_o.irq = 1'b1;
        pin_oe.irq = cur_q.irq_act;
      end else begin
        pin_oe.irq = cur_q.irq_act;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: transmit capture on the mii clock

  typedef struct packed {
    logic [3:0] txd;
    logic txen;
  } link_state_t;

  link_state_t lnk_q;
  link_state_t lnk_d;

  // mac owns timing here, nibble is only meaningful while txen is high
  always_comb begin
    lnk_d.txd = txd_pin;
    lnk_d.txen = txen_pin;
  end

  always_ff @(posedge clk_mii or negedge nrst) begin
    if (!nrst) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  assign tx_nibble = lnk_q.txd;
  assign tx_valid = lnk_q.txen;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  a_rx_drive_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_q.drive_en |-> (pin_oe.rxd == 4'hf) && pin_oe.rxdv && pin_oe.rxc && pin_oe.rxer)
    else $error("receive pins not driven");
  a_irq_low_pol: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_q.drive_en && !opt2 && !pol_high && cur_q.irq_act |-> pin_oe.irq && !pin_o.irq)
    else $error("active low irq not driven low");
  a_irq_high_pol: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_q.drive_en && !opt2 && pol_high && cur_q.irq_act |-> pin_oe.irq && pin_o.irq)
    else $error("active high irq not driven high");
  a_irq_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && |(irq_event & cur_q.irq_en) |=> cur_q.irq_act)
    else $error("enabled event did not raise irq");
  a_wake_low: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && lan_wakeup && straps.wake_out_enable_strap |=> ##1 (!opt2 || !cur_q.drive_en ||
    (pin_oe.irq && !pin_o.irq))) else $error("wake event not signalled");
  a_txc_dir: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_q.drive_en |-> pin_oe.txc == !cur_q.ctrl[b2b_bit])
    else $error("tx clock direction wrong");
  a_tx_capture: assert property (@(posedge clk_mii) disable iff (!nrst)
    1'b1 |=> tx_valid == $past(txen_pin)) else $error("txen not captured");
  a_rx_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_q.drive_en |-> pin_o.rxd == rx_in.rxd && pin_o.rxdv == rx_in.rxdv)
    else $error("receive nibble not passed");
  a_drive_after: assert property (@(posedge clk_sys) disable iff (!nrst)
    !strap_done |=> !cur_q.drive_en) else $error("pins driven before strap capture");

  c_irq_fire: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(cur_q.irq_act));
  c_wake_pin: cover property (@(posedge clk_sys) disable iff (!nrst) opt2 && pin_oe.irq);
  c_b2b_mode: cover property (@(posedge clk_sys) disable iff (!nrst) cur_q.drive_en && !pin_oe.txc);
  c_tx_frame: cover property (@(posedge clk_mii) disable iff (!nrst) $rose(tx_valid));

endmodule : mii_pin_share
`default_nettype wire

/* tb/mac_model.sv */
// mac model: the transmit side of the mii link, driven on the link clock
`timescale 1ns/10ps
`default_nettype none
module mac_model (
  input wire logic clk_mii, // link clock
  input wire logic send,    // bench asks for a frame
  output logic txen,        // transmit enable
  output logic [3:0] txd    // transmit nibble
);
  logic [3:0] cnt_q;
  initial begin
    txen = 1'b0;
    txd = 4'h5;
    cnt_q = 4'h0;
  end
  // changes just after the link edge; idle nibble flips so stale data never looks valid
  always @(posedge clk_mii) begin
    cnt_q <= cnt_q + 4'h3;
    txen <= send;
    txd <= send ? cnt_q : ~txd;
  end
endmodule : mac_model
`default_nettype wire

/* tb/testbench.sv */
// testbench: strap capture, pin sharing, interrupt pin and link side of mii_pin_share
`timescale 1ns/10ps
`default_nettype none
module testbench
  import strap_pkg::*;
;
  typedef struct packed {
    pins_t pull;
    straps_t want;
  } row_t;
  logic clk_sys, clk_mii, nrst, ce, psel, penable, pwrite, pready, pslverr, er;
  logic lan_wakeup, tx_clk_gen, send, txen, tx_valid, pv, mon_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [irq_w-1:0] irq_event;
  logic [3:0] txd, tx_nibble, pn;
  rx_word_t rx_in;
  pins_t pull, pin_i, pin_o, pin_oe;
  straps_t straps;
  int failures, cmp_count, cyc, tx_cnt;
  // one row per strap pin group; address pins land bit-reversed
  row_t rows[6] = '{'{9'h100, 9'h040}, '{9'h080, 9'h080}, '{9'h040, 9'h100},
                    '{9'h020, 9'h020}, '{9'h01f, 9'h01f}, '{9'h1ff, 9'h1ff}};

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    clk_mii = 1'b0;
    #1.3;
    forever #7.5 clk_mii = ~clk_mii;
  end
  // wire level: the driver wins, else the board pull shows
  assign pin_i = (pin_o & pin_oe) | (pull & ~pin_oe);

  mii_pin_share i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .clk_mii(clk_mii),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_event(irq_event),
    .lan_wakeup(lan_wakeup), .rx_in(rx_in), .tx_clk_gen(tx_clk_gen), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .txen_pin(txen), .txd_pin(txd),
    .tx_nibble(tx_nibble), .tx_valid(tx_valid), .straps(straps));
  mac_model i_mac (.clk_mii(clk_mii), .send(send), .txen(txen), .txd(txd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      failures++;
      $display("BAD %0t word got %h expected %h", $time, got, want);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic want);
    cmp_count++;
    if (got !== want) begin
      failures++;
      $display("BAD %0t bit got %b expected %b", $time, got, want);
    end
  endtask : chk_bit
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // ends once pready is seen; only the bench cycle limit ends a hung wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask : wr
  task automatic pulse(input logic [irq_w-1:0] ev, input logic wk);
    @(posedge clk_sys);
    irq_event <= ev;
    lan_wakeup <= wk;
    @(posedge clk_sys);
    irq_event <= irq_zero;
    lan_wakeup <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : pulse
  task automatic do_reset(input pins_t p);
    @(posedge clk_sys);
    pull <= p;
    nrst <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk_word(32'(pin_oe), 32'h0);
    chk_word(32'(straps), 32'h0);
    nrst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : do_reset
  function automatic logic [31:0] strap_word(input straps_t s);
    return {23'h0, s.wake_out_enable_strap, s.nand_tree, s.isolate,
            s.broadcast_disable_strap, s.mode_cfg_strap_bit2, s.duplex, s.mgmt_address};
  endfunction : strap_word

  ////////////////////////////////////////////////////////////////////////////////
  // link side: outputs trail the mac pins by one link edge
  always @(negedge clk_mii) begin
    if (mon_on) begin
      chk_bit(tx_valid, pv);
      if (pv) chk_word(32'(tx_nibble), 32'(pn));
      if (pv) tx_cnt++;
    end
    pv = txen;
    pn = txd;
  end
  always @(posedge clk_sys) begin
    tx_clk_gen <= ~tx_clk_gen;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    nrst = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; irq_event = irq_zero; lan_wakeup = 1'b0; tx_clk_gen = 1'b0;
    send = 1'b0; rx_in = '0; pull = '0; pv = 1'b0; pn = 4'h0; mon_on = 1'b0;
    failures = 0; cmp_count = 0; cyc = 0; tx_cnt = 0;
    foreach (rows[i]) begin
      do_reset(rows[i].pull);
      chk_word(32'(straps), 32'(rows[i].want));
      apb(1'b0, reg_strap_ofs, 32'h0, rd, er);
      chk_word(rd, strap_word(rows[i].want));
    end
    // pulls removed and a write tried: straps must not move
    pull <= '0;
    wr(reg_strap_ofs, 32'h0);
    apb(1'b0, reg_strap_ofs, 32'h0, rd, er);
    chk_word(rd, 32'h0000_01ff);
    apb(1'b0, reg_ctrl_ofs, 32'h0, rd, er);
    chk_word(rd, ctrl_rst);
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk_word(rd, 32'h0);
    chk_bit(er, 1'b1);
    rx_in <= '{rxd: 4'ha, rxdv: 1'b1, rxer: 1'b0};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bit(&{pin_oe.rxd, pin_oe.rxdv, pin_oe.rxc, pin_oe.rxer}, 1'b1);
    chk_word(32'({pin_o.rxd, pin_o.rxdv}), 32'h15);
    // interrupt: enabled, fired, read, cleared, then high polarity, then masked
    wr(reg_irq_ofs, 32'h0001_0000);
    pulse(8'h01, 1'b0);
    chk_word(32'({pin_oe.irq, pin_o.irq}), 32'h2);
    apb(1'b0, reg_irq_ofs, 32'h0, rd, er);
    chk_word(rd, 32'h0001_0001);
    wr(reg_irq_ofs, 32'h0001_0001);
    @(negedge clk_sys);
    chk_bit(pin_oe.irq, 1'b0);
    wr(reg_ctrl_ofs, 32'h0000_0200);
    pulse(8'h01, 1'b0);
    chk_word(32'({pin_oe.irq, pin_o.irq}), 32'h3);
    wr(reg_irq_ofs, 32'h0000_00ff);
    pulse(8'h80, 1'b0);
    chk_bit(pin_oe.irq, 1'b0);
    // wake event on option 2, wake output strap is set
    wr(reg_ctrl_ofs, 32'h0000_0001);
    pulse(irq_zero, 1'b1);
    chk_word(32'({pin_oe.irq, pin_o.irq}), 32'h2);
    apb(1'b0, reg_wake_ofs, 32'h0, rd, er);
    chk_word(rd, 32'h1);
    wr(reg_wake_ofs, 32'h1);
    @(negedge clk_sys);
    chk_bit(pin_oe.irq, 1'b0);
    // transmit clock pin: driven normally, released in back-to-back mode
    wr(reg_ctrl_ofs, 32'h0);
    @(negedge clk_sys);
    chk_word(32'({pin_oe.txc, pin_o.txc}), 32'({1'b1, tx_clk_gen}));
    wr(reg_ctrl_ofs, 32'h0000_0002);
    @(negedge clk_sys);
    chk_bit(pin_oe.txc, 1'b0);
    // clock enable low: a register write must not land
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(reg_ctrl_ofs, 32'h0000_0200);
    ce <= 1'b1;
    apb(1'b0, reg_ctrl_ofs, 32'h0, rd, er);
    chk_word(rd, 32'h0000_0002);
    mon_on = 1'b1;
    send <= 1'b1;
    repeat (40) @(posedge clk_sys);
    send <= 1'b0;
    repeat (20) @(posedge clk_sys);
    mon_on = 1'b0;
    chk_bit(tx_cnt > 5, 1'b1);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
